// *** design/pvs_pkg.sv ***
/*
  Package for the pin volume converter control block: register offsets,
  field positions, reset values, converter timing and the shared structs.
  Assumes a register port of its own: page-qualified 7-bit register address.
*/
package pvs_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [6:0] PVS_OFS_PAGE    = 7'h00;
  localparam logic [6:0] PVS_OFS_CTRL    = 7'h74;
  localparam logic [6:0] PVS_OFS_GAIN    = 7'h75;
  localparam logic [7:0] PVS_PAGE_CTRL   = 8'h00;
  localparam logic [7:0] PVS_RST_PAGE    = 8'h00;
  localparam logic [7:0] PVS_RST_CTRL    = 8'h00;

  // Field positions of the converter control register
  localparam int PVS_BIT_SRC     = 7;
  localparam int PVS_BIT_CLKSEL  = 6;
  localparam int PVS_HYS_HI      = 5;
  localparam int PVS_HYS_LO      = 4;
  localparam int PVS_RATE_HI     = 2;
  localparam int PVS_RATE_LO     = 0;
  localparam logic [7:0] PVS_CTRL_WMASK = 8'hF7;

  // Hysteresis codes
  localparam logic [1:0] PVS_HYS_NONE = 2'h0;
  localparam logic [1:0] PVS_HYS_ONE  = 2'h1;
  localparam logic [1:0] PVS_HYS_TWO  = 2'h2;

  // ****************************************************************
  // Converter timing
  // ****************************************************************
  // Reference clock 12 MHz gives 15.625 Hz at rate code 0:
  // 12e6 / 15.625 = 768000 reference cycles per conversion at code 0.
  localparam int PVS_REF_HZ       = 12000000;
  localparam int PVS_BASE_RATE_MHZ = 15625; // milli-hertz
  localparam int PVS_BASE_DIV =
    (PVS_REF_HZ / PVS_BASE_RATE_MHZ) * 1000;
  localparam int PVS_SAR_BITS     = 7;

  // Register access carrier
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [6:0] addr;
    logic [7:0] wdata;
  } pvs_reg_req_t;

  typedef struct packed {
    logic       src_pin;
    logic       clk_mclk;
    logic [1:0] hys;
    logic [2:0] rate;
  } pvs_ctrl_t;

endpackage : pvs_pkg

// *** design/pvs_sar.sv ***
/*
  Seven-bit successive-approximation sequencer for the volume sense pin.
  Assumes an external comparator answering whether the pin level is above
  the trial code, valid in the same cycle the trial code is presented.
*/
`timescale 1ns/1ns
`default_nettype none
module pvs_sar #(
  parameter int W = 7
) (
  // Clock and reset
  input  wire logic         mclk,
  input  wire logic         rst_n,
  // Control
  input  wire logic         enable,
  input  wire logic         step,
  input  wire logic         start,
  // Comparator
  input  wire logic         cmp_above,
  output logic [W-1:0]      trial,
  // Result
  output logic              done,
  output logic [W-1:0]      result
);

  initial begin
    if (W < 2) $error("pvs_sar: width too small");
  end

  typedef enum logic [1:0] {
    PVS_S_IDLE = 2'b00,
    PVS_S_CONV = 2'b01,
    PVS_S_DONE = 2'b10
  } pvs_sar_st_t;

  typedef struct packed {
    pvs_sar_st_t  st;
    logic [W-1:0] code;
    logic [W-1:0] bitm;
    logic [W-1:0] res;
  } pvs_sar_state_t;

  pvs_sar_state_t s_q, s_d;

  // ****************************************************************
  // Bit-by-bit search, one bit per converter clock step
  // ****************************************************************
  always_comb begin
    s_d = s_q;
    case (s_q.st)
      PVS_S_IDLE: begin
        if (enable && start) begin
          s_d.st   = PVS_S_CONV;
          s_d.bitm = {1'b1, {(W-1){1'b0}}};
          s_d.code = {1'b1, {(W-1){1'b0}}};
        end
      end
      PVS_S_CONV: begin
        if (!enable) begin
          s_d.st = PVS_S_IDLE; // Powered down mid-conversion
        end else if (step) begin
          // Keep the trial bit while the pin sits above it
          if (!cmp_above) s_d.code = s_q.code & ~s_q.bitm;
          if (s_q.bitm[0]) begin
            s_d.st  = PVS_S_DONE;
            s_d.res = cmp_above ? s_q.code : (s_q.code & ~s_q.bitm);
          end else begin
            s_d.bitm = s_q.bitm >> 1;
            s_d.code = (cmp_above ? s_q.code : (s_q.code & ~s_q.bitm))
                       | (s_q.bitm >> 1);
          end
        end
      end
      PVS_S_DONE: s_d.st = PVS_S_IDLE;
      default:    s_d.st = PVS_S_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign trial  = s_q.code;
  assign done   = (s_q.st == PVS_S_DONE);
  assign result = s_q.res;

endmodule : pvs_sar
`default_nettype wire

// *** design/pvs_top.sv ***
/*
  Pin volume converter control: page select, converter control register,
  gain readback, rate timing, clock source choice and hysteresis.
  Assumes a simple synchronous register port from the serial control logic
  and an analogue comparator plus oscillator tick from the analogue side.
*/
`timescale 1ns/1ns
`default_nettype none
module pvs_top #(
  parameter int BASE_DIV = pvs_pkg::PVS_BASE_DIV,
  parameter int GAIN_W   = pvs_pkg::PVS_SAR_BITS
) (
  // Clock and reset
  input  wire logic                mclk,
  input  wire logic                rst_n,
  // Register port
  input  wire pvs_pkg::pvs_reg_req_t reg_req,
  output logic [7:0]               reg_rdata,
  // Analogue side of the volume sense pin
  input  wire logic                osc_tick,
  input  wire logic                cmp_above,
  output logic [GAIN_W-1:0]        sar_trial,
  output logic                     sar_power_on,
  // Volume to the playback path
  input  wire logic [GAIN_W-1:0]   reg_volume,
  output logic [GAIN_W-1:0]        dac_volume,
  output logic                     volume_from_pin
);

  initial begin
    if (BASE_DIV < 16) $error("pvs_top: BASE_DIV too small");
    if (GAIN_W != 7) $error("pvs_top: gain code must be 7 bits");
  end

  localparam int CNT_W = $clog2(BASE_DIV + 1);

  // ****************************************************************
  // Reset release
  // ****************************************************************
  logic [1:0] rst_sync_q;
  logic       rst_n_i;

  // Two flops so the release lands clean on mclk
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n_i = rst_sync_q[1];

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [7:0]        page;
    pvs_pkg::pvs_ctrl_t ctrl;
    logic [CNT_W-1:0]  rate_cnt;
    logic              start;
    logic [GAIN_W-1:0] applied;
    logic [GAIN_W-1:0] dac_vol;
    logic [7:0]        rdata;
  } pvs_state_t;

  pvs_state_t s_q, s_d;

  logic              sar_done;
  logic [GAIN_W-1:0] sar_result;
  logic              sar_step;
  logic [CNT_W-1:0]  rate_limit;
  logic [GAIN_W:0]   diff;
  logic              page0;

  assign page0 = (s_q.page == pvs_pkg::PVS_PAGE_CTRL);

  // Step source: master clock every cycle, or oscillator tick
  assign sar_step = s_q.ctrl.clk_mclk ? 1'b1 : osc_tick;

  // Period halves per rate code; on the oscillator the same count is in
  // oscillator ticks, so the rate follows the real oscillator
  assign rate_limit = CNT_W'(BASE_DIV >> s_q.ctrl.rate);

  // Distance between new result and applied code
  assign diff = (sar_result > s_q.applied)
              ? {1'b0, sar_result} - {1'b0, s_q.applied}
              : {1'b0, s_q.applied} - {1'b0, sar_result};

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb begin
    s_d       = s_q;
    s_d.start = 1'b0;

    // Register writes; page register sits at 0 of every page
    if (reg_req.wr) begin
      if (reg_req.addr == pvs_pkg::PVS_OFS_PAGE) begin
        s_d.page = reg_req.wdata;
      end else if (page0 && reg_req.addr == pvs_pkg::PVS_OFS_CTRL) begin
        // Reserved bit kept at reset value
        s_d.ctrl = pvs_pkg::pvs_ctrl_t'({reg_req.wdata[7:4],
                                          reg_req.wdata[2:0]});
      end
    end

    // Read data, registered
    s_d.rdata = 8'h00;
    if (reg_req.rd) begin
      if (reg_req.addr == pvs_pkg::PVS_OFS_PAGE) begin
        s_d.rdata = s_q.page;
      end else if (page0 && reg_req.addr == pvs_pkg::PVS_OFS_CTRL) begin
        s_d.rdata = {s_q.ctrl.src_pin, s_q.ctrl.clk_mclk, s_q.ctrl.hys,
                     1'b0, s_q.ctrl.rate};
      end else if (page0 && reg_req.addr == pvs_pkg::PVS_OFS_GAIN) begin
        s_d.rdata = {1'b0, s_q.applied};
      end
    end

    // Conversion rate timer, idle while converter is off
    if (!s_q.ctrl.src_pin) begin
      s_d.rate_cnt = '0;
    end else if (sar_step) begin
      if (s_q.rate_cnt >= rate_limit - CNT_W'(1)) begin
        s_d.rate_cnt = '0;
        s_d.start    = 1'b1;
      end else begin
        s_d.rate_cnt = s_q.rate_cnt + CNT_W'(1);
      end
    end

    // Hysteresis on the applied code
    if (sar_done) begin
      case (s_q.ctrl.hys)
        pvs_pkg::PVS_HYS_NONE: s_d.applied = sar_result;
        pvs_pkg::PVS_HYS_ONE:
          if (diff > (GAIN_W+1)'(1)) s_d.applied = sar_result;
        pvs_pkg::PVS_HYS_TWO:
          if (diff > (GAIN_W+1)'(2)) s_d.applied = sar_result;
        default: s_d.applied = s_q.applied; // Reserved: hold
      endcase
    end

    // Volume source choice
    s_d.dac_vol = s_q.ctrl.src_pin ? s_q.applied : reg_volume;
  end

  always_ff @(posedge mclk or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************************************
  // Converter sequencer
  // ****************************************************************
  pvs_sar #(
    .W (GAIN_W)
  ) u_sar (
    .mclk      (mclk),
    .rst_n     (rst_n_i),
    .enable    (s_q.ctrl.src_pin),
    .step      (sar_step),
    .start     (s_q.start),
    .cmp_above (cmp_above),
    .trial     (sar_trial),
    .done      (sar_done),
    .result    (sar_result)
  );

  // Outputs
  assign reg_rdata       = s_q.rdata;
  assign dac_volume      = s_q.dac_vol;
  assign volume_from_pin = s_q.ctrl.src_pin;
  assign sar_power_on    = s_q.ctrl.src_pin;

endmodule : pvs_top
`default_nettype wire

// *** bench/pvs_props.sv ***
/* Checker for the pin volume block ports.
   Assumes a bind onto every pvs_top instance. */
`timescale 1ns/1ns
`default_nettype none
module pvs_props #(
  parameter int GAIN_W = 7
) (
  // Clock and reset
  input wire logic              mclk,
  input wire logic              rst_n,
  // Register port
  input wire pvs_pkg::pvs_reg_req_t reg_req,
  input wire logic [7:0]        reg_rdata,
  // Volume outputs and the register volume input
  input wire logic              sar_power_on,
  input wire logic [GAIN_W-1:0] reg_volume,
  input wire logic [GAIN_W-1:0] dac_volume,
  input wire logic              volume_from_pin
);
  // ****************************************************************
  // Shadow of page and hysteresis
  // ****************************************************************
  logic [7:0]        page_q;
  logic [1:0]        hys_q;
  logic [GAIN_W-1:0] prev_q;
  wire logic a_pg = reg_req.addr == 7'h00;
  wire logic a_ct = reg_req.addr == 7'h74;
  wire logic a_gn = reg_req.addr == 7'h75;
  wire logic ctl  = reg_req.wr && a_ct && page_q == 8'h00;
  wire logic w7   = reg_req.wdata[7];
  wire logic [GAIN_W-1:0] dif = dac_volume > prev_q ?
    dac_volume - prev_q : prev_q - dac_volume;
  // Shadow copies follow writes the same way the block should
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      page_q <= 8'h00;
      hys_q  <= 2'h0;
      prev_q <= '0;
    end else begin
      if (reg_req.wr && a_pg) page_q <= reg_req.wdata;
      if (ctl) hys_q <= reg_req.wdata[5:4];
      prev_q <= dac_volume;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  power_tie_a: assert property (sar_power_on == volume_from_pin)
    else $error("power differs from source");
  src_write_a: assert property (ctl |=> volume_from_pin == $past(w7))
    else $error("source bit not taken");
  page_guard_a: assert property (
    reg_req.wr && a_ct && page_q != 8'h00 |=> $stable(volume_from_pin))
    else $error("write on other page took effect");
  reg_path_a: assert property (
    !volume_from_pin && !$past(volume_from_pin)
    |-> dac_volume == $past(reg_volume))
    else $error("register volume not applied");
  unmapped_read_a: assert property (
    reg_req.rd && !a_pg && (page_q != 8'h00 || !(a_ct || a_gn))
    |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  gain_read_a: assert property (
    reg_req.rd && a_gn && page_q == 8'h00 && volume_from_pin
    && $stable(dac_volume) |=> reg_rdata == {1'b0, $past(dac_volume)})
    else $error("gain readback wrong");
  page_read_a: assert property (
    reg_req.rd && a_pg |=> reg_rdata == $past(page_q))
    else $error("page readback wrong");
  hys_hold_a: assert property (
    volume_from_pin && $past(volume_from_pin, 2) && dac_volume != prev_q
    |-> hys_q != 2'h3 && dif > GAIN_W'(hys_q))
    else $error("volume moved inside hysteresis");
endmodule : pvs_props
bind pvs_top pvs_props #(.GAIN_W(GAIN_W)) u_props (.mclk(mclk), .rst_n(rst_n),
  .reg_req(reg_req), .reg_rdata(reg_rdata), .sar_power_on(sar_power_on),
  .reg_volume(reg_volume), .dac_volume(dac_volume),
  .volume_from_pin(volume_from_pin));
`default_nettype wire

// *** bench/pvs_pot.sv ***
/* Potentiometer level on the volume sense pin.
   Assumes the bench sets the level; comparator is ideal. */
`timescale 1ns/1ns
`default_nettype none
module pvs_pot (
  // Level and trial code
  input  wire logic [6:0] level,
  input  wire logic [6:0] sar_trial,
  // Comparator answer
  output logic            cmp_above
);
  // No noise, so a full conversion lands exactly on the level
  assign cmp_above = (level >= sar_trial);
endmodule : pvs_pot
`default_nettype wire

// *** bench/pvs_top_tb.sv ***
/* Testbench for pvs_top with a register and converter model.
   Assumes pvs_props and pvs_pot are compiled alongside. */
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_fail++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module pvs_top_tb;
  logic mclk = 0, rst_n = 0, osc_tick = 0, osc_on = 0, cmp, pwr, vfp;
  pvs_pkg::pvs_reg_req_t req = '0;
  logic [7:0] rdata;
  logic [6:0] trial, dac, regv = '0, lvl = '0;
  int n_fail = 0, cmp_count = 0, page = 0, ctrl = 0, appl = 0;
  always #5 mclk = ~mclk;
  // Oscillator pulses every second cycle while enabled
  always @(negedge mclk) osc_tick <= osc_on && !osc_tick;
  pvs_top #(.BASE_DIV(64)) u_dut (.mclk(mclk), .rst_n(rst_n),
    .reg_req(req), .reg_rdata(rdata), .osc_tick(osc_tick),
    .cmp_above(cmp), .sar_trial(trial), .sar_power_on(pwr),
    .reg_volume(regv), .dac_volume(dac), .volume_from_pin(vfp));
  pvs_pot u_pot (.level(lvl), .sar_trial(trial), .cmp_above(cmp));
  task automatic give_verdict;
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : give_verdict
  // Register write, model follows page and masked control
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(negedge mclk); req.wr = 1; req.addr = a; req.wdata = d;
    @(negedge mclk); req.wr = 0;
    if (a == 7'h00) page = d;
    else if (a == 7'h74 && page == 0) ctrl = d & 8'hF7;
  endtask : wr
  task automatic chk_rd(input logic [6:0] a);
    logic [7:0] e;
    e = a == 7'h00 ? 8'(page) : page != 0 ? 8'h00 :
        a == 7'h74 ? 8'(ctrl) : a == 7'h75 ? 8'(appl) : 8'h00;
    @(negedge mclk); req.rd = 1; req.addr = a;
    @(negedge mclk); req.rd = 0;
    `CHK(rdata, e)
  endtask : chk_rd
  // New pot level; long wait covers a whole conversion
  task automatic settle(input int v, input bit run);
    int dl;
    @(negedge mclk); lvl = 7'(v);
    repeat (120) @(negedge mclk);
    dl = v > appl ? v - appl : appl - v;
    if (run && ctrl[5:4] != 3 && (ctrl[5:4] == 0 || dl > ctrl[5:4]))
      appl = v;
    `CHK(dac, 7'(appl))
    chk_rd(7'h75);
  endtask : settle
  initial begin
    #400000 n_fail++;
    give_verdict();
  end
  initial begin
    void'($urandom(73141));
    repeat (8) @(negedge mclk);
    rst_n = 1;
    repeat (4) @(negedge mclk);
    chk_rd(7'h00);
    chk_rd(7'h74);
    wr(7'h74, 8'h0B);
    chk_rd(7'h74);
    repeat (4) begin
      @(negedge mclk); regv = 7'($urandom);
      @(negedge mclk);
      `CHK({pwr, dac}, {1'b0, regv})
    end
    wr(7'h00, 8'hFF);
    chk_rd(7'h00);
    wr(7'h74, 8'hC3);
    chk_rd(7'h74);
    chk_rd(7'h10);
    `CHK(vfp, 1'b0)
    wr(7'h00, 8'h00);
    wr(7'h74, 8'hC3);
    `CHK({pwr, vfp}, 2'h3)
    settle(0, 1);
    settle('h7E, 1);
    settle('h5B, 1);
    repeat (3) settle($urandom % 128, 1);
    // Only the legal hysteresis codes; 11 is never written by software
    for (int h = 1; h < 3; h++) begin
      wr(7'h74, 8'hC3);
      settle('h40, 1);
      wr(7'h74, 8'(8'hC3 | h << 4));
      for (int k = 1; k < 4; k++) settle(appl + k, 1);
    end
    wr(7'h74, 8'h83);
    settle('h20, 0);
    osc_on = 1;
    settle('h21, 1);
    give_verdict();
  end
endmodule : pvs_top_tb
`default_nettype wire
